// ===== design/tsm_map.vh
// What this block does
// - Trap enable bit 4 and trap flag bit 5 raise trap request, vector 14.
// - Bits 6/7 fail enable and test interrupt; halts sequencer, clears DMA.
// - Test interrupt blocks compare; stop/trip summary masks held bit 7 out of test interrupt.
// - Trap, fail and delay done share one priority level; vector picks trap, then fail, then delay done.
// - Status bit 8 enables trips; when clear, trip inputs cannot set flags 9-11.
// - Trips set only with DMA off, phase 5 or X7; ignored on monitor+strobe.
// - Enabled trip flag raises trip request and test interrupt, vector 16.
// - Stop enable bit 12 survives status clear; flag 13 raises stop request.
// - Short register reset sets stop flag; stop blocks every other request except trip.
// - Bit 14 reads inverse of stop flag; station write clears stop flag.
// - All 16 status bits write over the host data bus; all but bit 14 read back.
// - Mode bit 0 write pulses short reset; stop enable and station spared.
// - Mode bit 1 write pulses long reset; bits 0 and 1 are write-only.
// - Mode bits 2 and 3 read monitor switch and automatic mode.
// - Mode bit 4 selects inverted pass/fail decisions.
// - Mode bit 5 clear means fail capture clears in the same cycle as each strobe.
// - Mode bit 6 suppresses the automatic strobe at delay loop end.
// - Writing mode bit 7 gives one-clock strobe despite strobe inhibit.
// - Mode bit 8 write starts delay, sync pulse until done, then gate clocks.
// - Mode bit 9 enters DMA; cleared by test interrupt, phase-5, or trap.
// - Mode bit 11 sets on fail with next test loaded; clears on DMA resume.
// - Strobe sets pass bit 14 if passing; fail sets 13, trip sets 12.
// - Fail bits stay in automatic; manual strobe refreshes; start sets pass.
// - Host clears status in the routine then re-enables; stop enable kept.
`ifndef TSM_MAP_VH
`define TSM_MAP_VH
`define TSM_ST_CMP_EN 0
`define TSM_ST_CMP 1
`define TSM_ST_DLC_EN 2
`define TSM_ST_DLC 3
`define TSM_ST_TRAP_EN 4
`define TSM_ST_TRAP 5
`define TSM_ST_FAIL_EN 6
`define TSM_ST_FTI 7
`define TSM_ST_TRIP_EN 8
`define TSM_ST_TRIP_LO 9
`define TSM_ST_STOP_EN 12
`define TSM_ST_STOP 13
`define TSM_ST_RUN 14
`define TSM_MD_SHORT 0
`define TSM_MD_LONG 1
`define TSM_MD_MON 2
`define TSM_MD_AUTO 3
`define TSM_MD_NEG 4
`define TSM_MD_ACC 5
`define TSM_MD_INH 6
`define TSM_MD_STROBE 7
`define TSM_MD_SYNC 8
`define TSM_MD_DMA 9
`define TSM_MD_SPARE_LO 10
`define TSM_MD_SUSP 11
`define TSM_MD_DCFAIL 12
`define TSM_MD_FFAIL 13
`define TSM_MD_PASS 14
`define TSM_MD_SPARE_HI 15
`define TSM_VEC_CMP 6'o20
`define TSM_VEC_DLC 6'o13
`define TSM_VEC_TRAP 6'o14
`define TSM_VEC_FAIL 6'o15
`define TSM_VEC_TRIP 6'o16
`define TSM_VEC_STOP 6'o00
`define TSM_STATUS_RESET 16'h0000
`define TSM_MODE_RESET 16'h0000
`endif

// ===== design/tsm_prio.v
`include "tsm_map.vh"

// Combinational request priority from the status register contents.
module tsm_prio (
  // Status image
  input wire [15:0] stat_in,
  // Requests and vector
  output wire stop_or_trip_active_out,
  output wire mid_priority_active_out,
  output wire functional_test_interrupt_out,
  output wire trap_request_out,
  output wire supply_trip_request_out,
  output wire irq_out,
  output reg [5:0] vector_out
);

  wire stop_request;
  wire fail_enable_request;
  wire delay_done_request;
  wire compare_request;
  wire trip_any;

  assign trip_any = |stat_in[`TSM_ST_TRIP_LO+2:`TSM_ST_TRIP_LO];
  assign supply_trip_request_out = trip_any & stat_in[`TSM_ST_TRIP_EN];
  assign stop_request = stat_in[`TSM_ST_STOP] & stat_in[`TSM_ST_STOP_EN];
  assign stop_or_trip_active_out = stop_request | supply_trip_request_out;
  assign trap_request_out = stat_in[`TSM_ST_TRAP] & stat_in[`TSM_ST_TRAP_EN]
    & ~stop_or_trip_active_out;
  assign delay_done_request = stat_in[`TSM_ST_DLC] & stat_in[`TSM_ST_DLC_EN]
    & ~stop_or_trip_active_out;
  // The fail enable gates the held test interrupt bit into a request.
  assign fail_enable_request = stat_in[`TSM_ST_FTI] & stat_in[`TSM_ST_FAIL_EN]
    & ~stop_or_trip_active_out;
  // The three share one level via an OR; the vector chain orders trap, fail, delay done.
  assign mid_priority_active_out = trap_request_out | delay_done_request
    | fail_enable_request;
  assign functional_test_interrupt_out = (stat_in[`TSM_ST_FTI]
    & ~stop_or_trip_active_out) | supply_trip_request_out;
  assign compare_request = stat_in[`TSM_ST_CMP] & stat_in[`TSM_ST_CMP_EN]
    & ~stop_or_trip_active_out & ~mid_priority_active_out
    & ~functional_test_interrupt_out;
  assign irq_out = stop_or_trip_active_out | mid_priority_active_out
    | compare_request;

  always @*
  begin
    if (stop_request)
      vector_out = `TSM_VEC_STOP;
    else if (supply_trip_request_out)
      vector_out = `TSM_VEC_TRIP;
    else if (trap_request_out)
      vector_out = `TSM_VEC_TRAP;
    else if (fail_enable_request)
      vector_out = `TSM_VEC_FAIL;
    else if (delay_done_request)
      vector_out = `TSM_VEC_DLC;
    else if (compare_request)
      vector_out = `TSM_VEC_CMP;
    else
      vector_out = 6'h00;
  end

endmodule

// ===== design/tsm_regs.v
`include "tsm_map.vh"

module tsm_regs (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // Host data bus and strobes
  input wire [15:0] pdata_in,
  input wire status_read_strobe_in,
  input wire status_write_strobe_in,
  input wire status_clear_strobe_in,
  input wire mode_read_strobe_in,
  input wire mode_write_strobe_in,
  input wire mode_clear_strobe_in,
  input wire station_control_write_in,
  output reg [15:0] pdata_out,
  output reg pdata_oe_out,
  // Tester events
  input wire compare_set_in,
  input wire delay_done_set_in,
  input wire trap_set_in,
  input wire [2:0] trip_in,
  input wire phase5_in,
  input wire delay_loop_final_state_in,
  input wire auto_strobe_in,
  input wire pin_fail_strobe_in,
  input wire next_test_loaded_in,
  input wire dma_clear_after_phase_in,
  input wire dma_clear_on_trap_in,
  input wire begin_command_in,
  input wire delay_count_done_in,
  input wire monitor_on_in,
  input wire auto_mode_in,
  // Controls to the tester
  output reg interrupt_request_out,
  output reg [5:0] vector_out,
  output reg trap_request_out,
  output reg supply_trip_request_out,
  output reg mid_priority_active_out,
  output reg stop_or_trip_active_out,
  output reg functional_test_interrupt_out,
  output reg run_bit_out,
  output reg short_reg_clear_out,
  output reg long_reg_clear_out,
  output reg inverted_logic_select_out,
  output reg fail_accumulate_out,
  output reg strobe_inhibit_out,
  output reg strobe_out,
  output reg fail_capture_clear_out,
  output reg sync_pulse_out,
  output reg delay_start_out,
  output reg gate_all_sync_out,
  output reg dma_mode_out,
  output reg test_suspended_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [15:0] stat_q;
  reg [15:0] stat_d;
  reg [15:0] mode_q;
  reg [15:0] mode_d;
  reg sync_q;
  reg dma_prev_q;

  wire p_stop_trip;
  wire p_mid;
  wire p_fti;
  wire p_trap;
  wire p_trip;
  wire p_irq;
  wire [5:0] p_vec;
  wire short_clr;
  wire strobe_now;
  wire manual_strobe;
  wire trip_window;
  wire [2:0] trip_set;
  wire fail_now;
  wire dma_resume;
  wire [15:0] stat_img;
  wire [15:0] mode_img;

  tsm_prio u_prio (
    .stat_in(stat_q),
    .stop_or_trip_active_out(p_stop_trip),
    .mid_priority_active_out(p_mid),
    .functional_test_interrupt_out(p_fti),
    .trap_request_out(p_trap),
    .supply_trip_request_out(p_trip),
    .irq_out(p_irq),
    .vector_out(p_vec)
  );

  assign short_clr = mode_write_strobe_in & pdata_in[`TSM_MD_SHORT];
  assign manual_strobe = mode_write_strobe_in & pdata_in[`TSM_MD_STROBE];
  // Manual strobe ignores inhibit; automatic one honours it.
  assign strobe_now = manual_strobe
    | (auto_strobe_in & ~mode_q[`TSM_MD_INH]);
  assign trip_window = ~mode_q[`TSM_MD_DMA] | phase5_in
    | delay_loop_final_state_in;
  assign trip_set = trip_in & {3{stat_q[`TSM_ST_TRIP_EN] & trip_window
    & ~(monitor_on_in & strobe_now)}};
  assign fail_now = strobe_now & pin_fail_strobe_in;
  assign dma_resume = mode_q[`TSM_MD_DMA] & ~dma_prev_q;
  // Bit 14 shows the inverse of the stop flag rather than stored data.
  assign stat_img = {stat_q[15], ~stat_q[`TSM_ST_STOP], stat_q[13:0]};
  assign mode_img = {mode_q[15:4], auto_mode_in, monitor_on_in, 2'b00};

  // ****************************************************************
  // Status register next state
  // ****************************************************************
  always @*
  begin
    stat_d = stat_q;
    if (status_write_strobe_in)
      stat_d = pdata_in;
    if (status_clear_strobe_in | short_clr)
    begin
      stat_d = `TSM_STATUS_RESET;
      stat_d[`TSM_ST_STOP_EN] = stat_q[`TSM_ST_STOP_EN];
    end
    if (station_control_write_in)
      stat_d[`TSM_ST_STOP] = 1'b0;
    // Hardware sets follow the clears so an event in the clear cycle wins.
    if (short_clr)
      stat_d[`TSM_ST_STOP] = 1'b1;
    if (compare_set_in)
      stat_d[`TSM_ST_CMP] = 1'b1;
    if (delay_done_set_in & ~mode_q[`TSM_MD_DMA])
      stat_d[`TSM_ST_DLC] = 1'b1;
    if (trap_set_in)
      stat_d[`TSM_ST_TRAP] = 1'b1;
    if (fail_now & stat_q[`TSM_ST_FAIL_EN])
      stat_d[`TSM_ST_FTI] = 1'b1;
    stat_d[`TSM_ST_TRIP_LO+2:`TSM_ST_TRIP_LO] =
      stat_d[`TSM_ST_TRIP_LO+2:`TSM_ST_TRIP_LO] | trip_set;
  end

  // ****************************************************************
  // Mode register next state
  // ****************************************************************
  always @*
  begin
    mode_d = mode_q;
    mode_d[`TSM_MD_SHORT] = 1'b0;
    mode_d[`TSM_MD_LONG] = 1'b0;
    mode_d[`TSM_MD_MON] = 1'b0;
    mode_d[`TSM_MD_AUTO] = 1'b0;
    mode_d[`TSM_MD_STROBE] = 1'b0;
    mode_d[`TSM_MD_SYNC] = 1'b0;
    if (mode_clear_strobe_in | short_clr)
      mode_d = `TSM_MODE_RESET;
    else if (mode_write_strobe_in)
    begin
      mode_d[`TSM_MD_NEG] = pdata_in[`TSM_MD_NEG];
      mode_d[`TSM_MD_ACC] = pdata_in[`TSM_MD_ACC];
      mode_d[`TSM_MD_INH] = pdata_in[`TSM_MD_INH];
      mode_d[`TSM_MD_SPARE_LO] = pdata_in[`TSM_MD_SPARE_LO];
      mode_d[`TSM_MD_SPARE_HI] = pdata_in[`TSM_MD_SPARE_HI];
      mode_d[`TSM_MD_SUSP] = pdata_in[`TSM_MD_SUSP];
      mode_d[14:12] = pdata_in[14:12];
      if (pdata_in[`TSM_MD_DMA])
        mode_d[`TSM_MD_DMA] = 1'b1;
    end
    if (p_fti | dma_clear_after_phase_in | dma_clear_on_trap_in)
      mode_d[`TSM_MD_DMA] = 1'b0;
    if (dma_resume)
      mode_d[`TSM_MD_SUSP] = 1'b0;
    if (fail_now & next_test_loaded_in)
      mode_d[`TSM_MD_SUSP] = 1'b1;
    // Pass and fail bookkeeping on each strobe.
    if (strobe_now)
    begin
      if (fail_now)
      begin
        mode_d[`TSM_MD_FFAIL] = 1'b1;
        mode_d[`TSM_MD_PASS] = 1'b0;
      end
      else if (~auto_mode_in)
      begin
        mode_d[`TSM_MD_FFAIL] = 1'b0;
        mode_d[`TSM_MD_PASS] = ~mode_d[`TSM_MD_DCFAIL];
      end
      else if (~mode_d[`TSM_MD_FFAIL] & ~mode_d[`TSM_MD_DCFAIL])
        mode_d[`TSM_MD_PASS] = 1'b1;
    end
    if (p_trip)
    begin
      mode_d[`TSM_MD_DCFAIL] = 1'b1;
      mode_d[`TSM_MD_PASS] = 1'b0;
    end
    if (begin_command_in)
    begin
      mode_d[`TSM_MD_PASS] = 1'b1;
      mode_d[`TSM_MD_FFAIL] = 1'b0;
      mode_d[`TSM_MD_DCFAIL] = 1'b0;
    end
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stat_q <= `TSM_STATUS_RESET;
      mode_q <= `TSM_MODE_RESET;
      sync_q <= 1'b0;
      dma_prev_q <= 1'b0;
      pdata_out <= 16'h0000;
      pdata_oe_out <= 1'b0;
      interrupt_request_out <= 1'b0;
      vector_out <= 6'h00;
      trap_request_out <= 1'b0;
      supply_trip_request_out <= 1'b0;
      mid_priority_active_out <= 1'b0;
      stop_or_trip_active_out <= 1'b0;
      functional_test_interrupt_out <= 1'b0;
      run_bit_out <= 1'b1;
      short_reg_clear_out <= 1'b0;
      long_reg_clear_out <= 1'b0;
      inverted_logic_select_out <= 1'b0;
      fail_accumulate_out <= 1'b0;
      strobe_inhibit_out <= 1'b0;
      strobe_out <= 1'b0;
      fail_capture_clear_out <= 1'b0;
      sync_pulse_out <= 1'b0;
      delay_start_out <= 1'b0;
      gate_all_sync_out <= 1'b0;
      dma_mode_out <= 1'b0;
      test_suspended_out <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mode_q <= mode_d;
      dma_prev_q <= mode_q[`TSM_MD_DMA];
      if (mode_write_strobe_in & pdata_in[`TSM_MD_SYNC])
        sync_q <= 1'b1;
      else if (delay_count_done_in)
        sync_q <= 1'b0;
      pdata_oe_out <= status_read_strobe_in | mode_read_strobe_in;
      if (status_read_strobe_in)
        pdata_out <= stat_img;
      else if (mode_read_strobe_in)
        pdata_out <= mode_img;
      else
        pdata_out <= 16'h0000;
      interrupt_request_out <= p_irq;
      vector_out <= p_vec;
      trap_request_out <= p_trap;
      supply_trip_request_out <= p_trip;
      mid_priority_active_out <= p_mid;
      stop_or_trip_active_out <= p_stop_trip;
      functional_test_interrupt_out <= p_fti;
      run_bit_out <= ~stat_d[`TSM_ST_STOP];
      short_reg_clear_out <= short_clr;
      long_reg_clear_out <= mode_write_strobe_in & pdata_in[`TSM_MD_LONG];
      inverted_logic_select_out <= mode_d[`TSM_MD_NEG];
      fail_accumulate_out <= mode_d[`TSM_MD_ACC];
      strobe_inhibit_out <= mode_d[`TSM_MD_INH];
      strobe_out <= strobe_now;
      fail_capture_clear_out <= strobe_now & ~mode_q[`TSM_MD_ACC];
      sync_pulse_out <= sync_q;
      delay_start_out <= mode_write_strobe_in & pdata_in[`TSM_MD_SYNC];
      gate_all_sync_out <= sync_q & delay_count_done_in;
      dma_mode_out <= mode_d[`TSM_MD_DMA];
      test_suspended_out <= mode_d[`TSM_MD_SUSP];
    end
  end

endmodule

// ===== testbench/tsm_host_model.sv
// ********************
// Host processor on the peripheral bus
// ********************
module tsm_host_model (
  // Clock and read return
  input logic clk_in,
  input logic [15:0] pdata_in,
  input logic pdata_oe_in,
  // Write data and strobes
  output logic [15:0] pdata_out,
  output logic [6:0] strobe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    pdata_out = 16'h0000;
    strobe_out = 7'h00;
  end
  // Released data lines show the inverse so nothing looks held.
  task automatic op(input int s, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk_in);
    #1;
    pdata_out = d;
    strobe_out = 7'h01 << s;
    @(posedge clk_in);
    #1;
    strobe_out = 7'h00;
    pdata_out = ~d;
    q = pdata_oe_in ? pdata_in : 16'hxxxx;
  endtask
endmodule

// ===== testbench/tsm_regs_properties.sv
// ********************
// Port properties of the register block
// ********************
module tsm_regs_properties (
  // Clock, reset, host side and tester inputs
  input logic clk_in,
  input logic rstn_in,
  input logic [15:0] pdata_in,
  input logic status_read_strobe_in,
  input logic mode_read_strobe_in,
  input logic mode_write_strobe_in,
  input logic delay_count_done_in,
  input logic monitor_on_in,
  input logic auto_mode_in,
  // Design outputs
  input logic [15:0] pdata_out,
  input logic pdata_oe_out,
  input logic interrupt_request_out,
  input logic [5:0] vector_out,
  input logic trap_request_out,
  input logic mid_priority_active_out,
  input logic stop_or_trip_active_out,
  input logic supply_trip_request_out,
  input logic short_reg_clear_out,
  input logic strobe_out,
  input logic sync_pulse_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_short_wr;
    mode_write_strobe_in && pdata_in[0];
  endsequence
  sequence s_sync_wr;
    mode_write_strobe_in && pdata_in[8] && !delay_count_done_in
      ##1 !delay_count_done_in;
  endsequence
  property p_trap;
    trap_request_out |-> interrupt_request_out && mid_priority_active_out
      && vector_out == 6'h0c;
  endproperty
  property p_trip;
    supply_trip_request_out |-> stop_or_trip_active_out && interrupt_request_out;
  endproperty
  property p_block;
    stop_or_trip_active_out |-> !trap_request_out && !mid_priority_active_out;
  endproperty
  property p_strobe;
    mode_write_strobe_in && pdata_in[7] |=> strobe_out;
  endproperty
  property p_short;
    s_short_wr |=> short_reg_clear_out ##1 !short_reg_clear_out;
  endproperty
  property p_sync;
    s_sync_wr |=> sync_pulse_out;
  endproperty
  property p_idle;
    !status_read_strobe_in && !mode_read_strobe_in |=> !pdata_oe_out;
  endproperty
  property p_mode;
    mode_read_strobe_in |=> pdata_oe_out && pdata_out[3:0] ==
      {$past(auto_mode_in), $past(monitor_on_in), 2'h0};
  endproperty
  a_trap: assert property (p_trap) else $error("trap");
  a_trip: assert property (p_trip) else $error("trip");
  a_block: assert property (p_block) else $error("block");
  a_strobe: assert property (p_strobe) else $error("strobe");
  a_short: assert property (p_short) else $error("short");
  a_sync: assert property (p_sync) else $error("sync");
  a_idle: assert property (p_idle) else $error("idle");
  a_mode: assert property (p_mode) else $error("mode");
endmodule
bind tsm_regs tsm_regs_properties tsm_regs_properties_i (
  .clk_in, .rstn_in, .pdata_in, .status_read_strobe_in,
  .mode_read_strobe_in, .mode_write_strobe_in, .delay_count_done_in,
  .monitor_on_in, .auto_mode_in, .pdata_out, .pdata_oe_out,
  .interrupt_request_out, .vector_out, .trap_request_out,
  .mid_priority_active_out, .stop_or_trip_active_out,
  .supply_trip_request_out, .short_reg_clear_out, .strobe_out,
  .sync_pulse_out
);

// ===== testbench/tsm_regs_tb.sv
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("Error %s exp %h got %h", nm, e, g); \
    end \
  end
// ********************
// Register block bench
// ********************
module tsm_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic trap = 0, ph5 = 0, pfail = 0, dphase = 0, dtrap = 0;
  logic bcmd = 0, done = 0, mon = 1, amode = 0;
  logic [2:0] trip = 3'h0;
  logic [15:0] wdata, rdata;
  logic [6:0] stb;
  logic [5:0] vec;
  logic oe, irq, trq, prq, mid, stop_or_trip_active, run, neg, acc, inh, sync, dma;
  int n_errors = 0, n_compared = 0, n_cycles = 0;
  tsm_host_model tsm_host_model_i (.clk_in, .pdata_in(rdata),
    .pdata_oe_in(oe), .pdata_out(wdata), .strobe_out(stb));
  tsm_regs tsm_regs_i (
    .clk_in, .rstn_in, .pdata_in(wdata),
    .status_read_strobe_in(stb[0]), .status_write_strobe_in(stb[1]),
    .status_clear_strobe_in(stb[2]), .mode_read_strobe_in(stb[3]),
    .mode_write_strobe_in(stb[4]), .mode_clear_strobe_in(stb[5]),
    .station_control_write_in(stb[6]), .pdata_out(rdata),
    .pdata_oe_out(oe), .compare_set_in(1'h0), .delay_done_set_in(1'h0),
    .trap_set_in(trap), .trip_in(trip), .phase5_in(ph5),
    .delay_loop_final_state_in(1'h0), .auto_strobe_in(1'h0),
    .pin_fail_strobe_in(pfail), .next_test_loaded_in(1'h0),
    .dma_clear_after_phase_in(dphase), .dma_clear_on_trap_in(dtrap),
    .begin_command_in(bcmd), .delay_count_done_in(done),
    .monitor_on_in(mon), .auto_mode_in(amode),
    .interrupt_request_out(irq), .vector_out(vec),
    .trap_request_out(trq), .supply_trip_request_out(prq),
    .mid_priority_active_out(mid), .stop_or_trip_active_out(stop_or_trip_active),
    .functional_test_interrupt_out(), .run_bit_out(run),
    .short_reg_clear_out(), .long_reg_clear_out(),
    .inverted_logic_select_out(neg), .fail_accumulate_out(acc),
    .strobe_inhibit_out(inh), .strobe_out(), .fail_capture_clear_out(),
    .sync_pulse_out(sync), .delay_start_out(), .gate_all_sync_out(),
    .dma_mode_out(dma), .test_suspended_out());
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input int s, input logic [15:0] d);
    logic [15:0] q;
    tsm_host_model_i.op(s, d, q);
  endtask
  task automatic rd(input int s, input logic [15:0] e, input string nm);
    logic [15:0] q;
    tsm_host_model_i.op(s, 16'h0000, q);
    `CHK(nm, e, q)
  endtask
  task automatic t_status;
    rd(0, 16'h4000, "status");
    amode = 1;
    rd(3, 16'h000c, "mode");
    amode = 0;
    wr(1, 16'hd150);
    rd(0, 16'hd150, "status rw");
    wr(2, 16'h0000);
    rd(0, 16'h5000, "cleared");
    wr(1, 16'h4000);
    rd(0, 16'h4000, "stop enable off");
  endtask
  task automatic t_trap;
    wr(1, 16'h4010);
    trap = 1;
    cyc(1);
    trap = 0;
    cyc(2);
    `CHK("trap", 3'h7, {trq, irq, mid})
    `CHK("vector", 6'h0c, vec)
    wr(2, 16'h0000);
    cyc(2);
    `CHK("irq off", 1'h0, irq)
  endtask
  task automatic t_trip;
    trip = 3'h2;
    cyc(2);
    rd(0, 16'h4000, "trip disabled");
    wr(4, 16'h0200);
    wr(1, 16'h4100);
    cyc(2);
    `CHK("dma", 2'h2, {dma, prq})
    ph5 = 1;
    cyc(3);
    `CHK("trip", 1'h1, prq)
    `CHK("vector", 6'h0e, vec)
    rd(0, 16'h4500, "trip flag");
    trip = 3'h0;
    ph5 = 0;
    wr(2, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      wr(4, 16'h0200);
      cyc(1);
      {dphase, dtrap} = 2'h1 << i;
      cyc(1);
      {dphase, dtrap} = 2'h0;
      cyc(2);
      `CHK("dma off", 1'h0, dma)
    end
  endtask
  task automatic t_stop;
    wr(1, 16'h5000);
    wr(4, 16'h0001);
    cyc(2);
    `CHK("stop", 8'h80, {irq, vec, run})
    rd(0, 16'h3000, "stop flag");
    wr(6, 16'h0000);
    cyc(2);
    `CHK("run", 1'h1, run)
    wr(1, 16'h4000);
  endtask
  task automatic t_mode;
    amode = 1;
    wr(4, 16'h8472);
    rd(3, 16'h847c, "mode rw");
    `CHK("controls", 3'h7, {neg, acc, inh})
    pfail = 1;
    wr(4, 16'h84f0);
    cyc(2);
    pfail = 0;
    // Bit 13 is written back as read so the held fail is not overwritten.
    wr(4, 16'ha4f0);
    cyc(2);
    rd(3, 16'ha47c, "auto fail");
    bcmd = 1;
    cyc(1);
    bcmd = 0;
    cyc(2);
    rd(3, 16'hc47c, "begin");
    amode = 0;
    wr(4, 16'h0100);
    cyc(3);
    `CHK("sync on", 1'h1, sync)
    done = 1;
    cyc(1);
    done = 0;
    cyc(4);
    `CHK("sync end", 1'h0, sync)
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    n_cycles++;
    if (n_cycles == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    cyc(20);
    rstn_in = 1'h1;
    cyc(1);
    t_status();
    t_trap();
    t_trip();
    t_stop();
    t_mode();
    end_of_test();
  end
endmodule
